/* verilog/uart_cfg_defs.svh */
// Register offsets, reset values, field positions and divider figures
// for the serial-port configuration bank; included by the bank only.
//
// Behaviour
// - Activation bit 0 turns the serial device off (0) or on (1).
// - Activation registers reset to 00h, so every serial device starts inactive.
// - Two byte registers hold base address 100h..FF8h, aligned to 8 bytes; the bank also accepts 000h..0F8h.
// - Base address resets are D 02h/E0h, E 03h/E8h, F 02h/E8h.
// - Interrupt select bits 3..0 pick the line; reset D,F 03h, E 04h.
// - Mode bit 6 picks level (0) or pulse (1) interrupt signalling for D,E.
// - Mode bit 5 picks original (0) or revised (1) receive FIFO error flag.
// - Mode bits 1..0: 00 gives 24 MHz/13, 01 gives 24 MHz/12.
// - Baud source also offers undivided 24 MHz and 24 MHz/1.625.
// - Device D mode bit 7: 0 delays receive clock 5 ns; E reserves it.
// - Mode registers reset to 00h; device D starts with receive delay on.
`ifndef UART_CFG_DEFS_SVH
`define UART_CFG_DEFS_SVH

`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
`define IDX_IRQ_SELECT 8'h70
`define IDX_MODE_CONTROL 8'hF0

`define DEV_D 2'h0
`define DEV_E 2'h1
`define DEV_F 2'h2

`define ACTIVATE_RST 8'h00
`define D_BASE_HIGH_RST 8'h02
`define D_BASE_LOW_RST 8'hE0
`define E_BASE_HIGH_RST 8'h03
`define E_BASE_LOW_RST 8'hE8
`define F_BASE_HIGH_RST 8'h02
`define F_BASE_LOW_RST 8'hE8
`define D_IRQ_RST 8'h03
`define E_IRQ_RST 8'h04
`define F_IRQ_RST 8'h03
`define MODE_RST 8'h00

`define ACTIVATE_MASK 8'h01
`define BASE_HIGH_MASK 8'h0F
`define BASE_LOW_MASK 8'hF8
`define IRQ_MASK 8'h0F
`define MODE_D_MASK 8'hE3
`define MODE_E_MASK 8'h63

`define ACT_BIT 0
`define RX_NODELAY_BIT 7
`define PULSE_BIT 6
`define FIFO_NEW_BIT 5
`define BAUD_HI 1
`define BAUD_LO 0

// Divider as modulus/step: output rate = input * step / modulus
`define DIV13_MOD 5'h0D
`define DIV13_STEP 5'h01
`define DIV12_MOD 5'h0C
`define DIV12_STEP 5'h01
`define DIV1_MOD 5'h01
`define DIV1_STEP 5'h01
`define DIV1625_MOD 5'h0D
`define DIV1625_STEP 5'h08

`endif

/* verilog/uart_cfg_pkg.sv */
// Types shared by the serial-port configuration bank.
// Assumes the bank's constants come from uart_cfg_defs.svh.
package uart_cfg_pkg;

    typedef enum logic [1:0] {
        BAUD_DIV13 = 2'h0,
        BAUD_DIV12 = 2'h1,
        BAUD_DIV1 = 2'h2,
        BAUD_DIV1625 = 2'h3
    } baud_sel_e;

    typedef struct packed {
        logic active;
        logic [11:0] base;
        logic [3:0] irq_sel;
        logic irq_pulse;
        logic fifo_err_new;
        logic rx_clk_nodelay;
        baud_sel_e baud_sel;
    } dev_cfg_s;

endpackage : uart_cfg_pkg

/* verilog/uart_cfg_bank.sv */
// Configuration bank for three serial logical devices, reached over APB,
// plus baud-rate tick dividers for the two devices with a mode register.
// Assumes tick_24mhz is a one-cycle enable at 24 MHz, synchronous to clock.
`include "uart_cfg_defs.svh"

module baud_divider (
    input wire logic clock, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic tick_in, // 24 MHz enable
    input wire uart_cfg_pkg::baud_sel_e sel, // Divider choice
    output logic tick_out // Baud source enable
);
    logic [4:0] acc;
    logic [4:0] modulus;
    logic [4:0] step;
    logic [4:0] sum;
    logic wrap;

    assign modulus = (sel == uart_cfg_pkg::BAUD_DIV13) ? `DIV13_MOD :
                     (sel == uart_cfg_pkg::BAUD_DIV12) ? `DIV12_MOD :
                     (sel == uart_cfg_pkg::BAUD_DIV1) ? `DIV1_MOD : `DIV1625_MOD;
    assign step = (sel == uart_cfg_pkg::BAUD_DIV1625) ? `DIV1625_STEP : `DIV13_STEP;
    assign sum = acc + step;
    assign wrap = sum >= modulus;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc <= 5'h00;
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && wrap;
            if (tick_in) begin
                acc <= wrap ? 5'(sum - modulus) : sum;
            end else if (acc >= modulus) begin
                acc <= 5'h00;
            end
        end
    end
endmodule : baud_divider

module uart_cfg_bank (
    input wire logic clock, // 250 MHz system clock
    input wire logic rstn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic tick_24mhz, // 24 MHz enable pulse
    output uart_cfg_pkg::dev_cfg_s cfg_d, // Device D settings
    output uart_cfg_pkg::dev_cfg_s cfg_e, // Device E settings
    output uart_cfg_pkg::dev_cfg_s cfg_f, // Device F settings
    output logic baud_tick_d, // Device D baud source enable
    output logic baud_tick_e // Device E baud source enable
);
    logic [7:0] act_q [3];
    logic [7:0] bh_q [3];
    logic [7:0] bl_q [3];
    logic [7:0] irq_q [3];
    logic [7:0] mode_q [2];

    wire [7:0] idx = paddr[9:2];
    wire [1:0] dev = paddr[11:10];
    wire dev_ok = (dev != 2'h3) && (paddr[31:12] == 20'h00000) && (paddr[1:0] == 2'h0);
    wire [1:0] dsel = dev_ok ? dev : `DEV_D;
    wire hit_act = idx == `IDX_ACTIVATE;
    wire hit_bh = idx == `IDX_BASE_HIGH;
    wire hit_bl = idx == `IDX_BASE_LOW;
    wire hit_irq = idx == `IDX_IRQ_SELECT;
    wire hit_mode = (idx == `IDX_MODE_CONTROL) && (dev != `DEV_F);
    wire mapped = dev_ok && (hit_act || hit_bh || hit_bl || hit_irq || hit_mode);
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite && mapped;
    wire [7:0] mode_rd = (dsel == `DEV_E) ? mode_q[1] : mode_q[0];
    wire [7:0] read_byte = hit_act ? act_q[dsel] :
                           hit_bh ? bh_q[dsel] :
                           hit_bl ? bl_q[dsel] :
                           hit_irq ? irq_q[dsel] :
                           hit_mode ? mode_rd : 8'h00;

    // Zero-wait slave: ready and data land in the first access cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite && mapped) ? {24'h000000, read_byte} : 32'h00000000;
        end
    end

    for (genvar d = 0; d < 3; d++) begin : g_dev
        localparam logic [7:0] BH_RST = (d == 0) ? `D_BASE_HIGH_RST :
                                        (d == 1) ? `E_BASE_HIGH_RST : `F_BASE_HIGH_RST;
        localparam logic [7:0] BL_RST = (d == 0) ? `D_BASE_LOW_RST :
                                        (d == 1) ? `E_BASE_LOW_RST : `F_BASE_LOW_RST;
        localparam logic [7:0] IRQ_RST = (d == 0) ? `D_IRQ_RST :
                                         (d == 1) ? `E_IRQ_RST : `F_IRQ_RST;
        wire dev_wr = wr_en && (dev == 2'(d));

        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                act_q[d] <= `ACTIVATE_RST;
                bh_q[d] <= BH_RST;
                bl_q[d] <= BL_RST;
                irq_q[d] <= IRQ_RST;
            end else if (dev_wr) begin
                if (hit_act) act_q[d] <= pwdata[7:0] & `ACTIVATE_MASK;
                if (hit_bh) bh_q[d] <= pwdata[7:0] & `BASE_HIGH_MASK;
                if (hit_bl) bl_q[d] <= pwdata[7:0] & `BASE_LOW_MASK;
                if (hit_irq) irq_q[d] <= pwdata[7:0] & `IRQ_MASK;
            end
        end
    end

    for (genvar m = 0; m < 2; m++) begin : g_mode
        localparam logic [7:0] MASK = (m == 0) ? `MODE_D_MASK : `MODE_E_MASK;

        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                mode_q[m] <= `MODE_RST;
            end else if (wr_en && hit_mode && (dev == 2'(m))) begin
                mode_q[m] <= pwdata[7:0] & MASK;
            end
        end
    end

    assign cfg_d = '{active: act_q[0][`ACT_BIT], base: {bh_q[0][3:0], bl_q[0]},
                     irq_sel: irq_q[0][3:0], irq_pulse: mode_q[0][`PULSE_BIT],
                     fifo_err_new: mode_q[0][`FIFO_NEW_BIT],
                     rx_clk_nodelay: mode_q[0][`RX_NODELAY_BIT],
                     baud_sel: uart_cfg_pkg::baud_sel_e'(mode_q[0][`BAUD_HI:`BAUD_LO])};
    assign cfg_e = '{active: act_q[1][`ACT_BIT], base: {bh_q[1][3:0], bl_q[1]},
                     irq_sel: irq_q[1][3:0], irq_pulse: mode_q[1][`PULSE_BIT],
                     fifo_err_new: mode_q[1][`FIFO_NEW_BIT],
                     rx_clk_nodelay: mode_q[1][`RX_NODELAY_BIT],
                     baud_sel: uart_cfg_pkg::baud_sel_e'(mode_q[1][`BAUD_HI:`BAUD_LO])};
    // Device F has no mode register: level interrupts, original flag, divide by 13
    assign cfg_f = '{active: act_q[2][`ACT_BIT], base: {bh_q[2][3:0], bl_q[2]},
                     irq_sel: irq_q[2][3:0], irq_pulse: 1'b0, fifo_err_new: 1'b0,
                     rx_clk_nodelay: 1'b0, baud_sel: uart_cfg_pkg::BAUD_DIV13};

    baud_divider u_baud_d (
        .clock(clock),
        .rstn(rstn),
        .tick_in(tick_24mhz),
        .sel(cfg_d.baud_sel),
        .tick_out(baud_tick_d)
    );

    baud_divider u_baud_e (
        .clock(clock),
        .rstn(rstn),
        .tick_in(tick_24mhz),
        .sel(cfg_e.baud_sel),
        .tick_out(baud_tick_e)
    );

    // Helper: 24 MHz ticks between device D baud ticks while code 00 held
    // The opening tick must come from code 00 too, or a residue shortens the gap
    logic [4:0] gap_d;
    logic gap_clean;
    logic sel13_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gap_d <= 5'h00;
            gap_clean <= 1'b0;
            sel13_q <= 1'b0;
        end else begin
            sel13_q <= cfg_d.baud_sel == uart_cfg_pkg::BAUD_DIV13;
            if (baud_tick_d) begin
                gap_d <= tick_24mhz ? 5'h01 : 5'h00;
                gap_clean <= sel13_q && (cfg_d.baud_sel == uart_cfg_pkg::BAUD_DIV13);
            end else begin
                gap_d <= tick_24mhz ? 5'(gap_d + 5'h01) : gap_d;
                if (cfg_d.baud_sel != uart_cfg_pkg::BAUD_DIV13) gap_clean <= 1'b0;
            end
        end
    end

    // Helper: device E spacing under code 01, checked from the third tick on
    // A residue left by an earlier code can shorten the first period by one
    logic [4:0] gap_e;
    logic gap_e_arm;
    logic gap_e_clean;
    logic sel12_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gap_e <= 5'h00;
            gap_e_arm <= 1'b0;
            gap_e_clean <= 1'b0;
            sel12_q <= 1'b0;
        end else begin
            sel12_q <= cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV12;
            if (baud_tick_e) begin
                gap_e <= tick_24mhz ? 5'h01 : 5'h00;
                gap_e_arm <= sel12_q && (cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV12);
                gap_e_clean <= gap_e_arm && (cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV12);
            end else begin
                gap_e <= tick_24mhz ? 5'(gap_e + 5'h01) : gap_e;
                if (cfg_e.baud_sel != uart_cfg_pkg::BAUD_DIV12) begin
                    gap_e_arm <= 1'b0;
                    gap_e_clean <= 1'b0;
                end
            end
        end
    end

    act_reset_a: assert property (@(posedge clock) $rose(rstn) |->
        !cfg_d.active && !cfg_e.active && !cfg_f.active)
        else $error("device active straight after reset");
    base_reset_a: assert property (@(posedge clock) $rose(rstn) |->
        cfg_d.base == 12'h2E0 && cfg_e.base == 12'h3E8 && cfg_f.base == 12'h2E8)
        else $error("base address reset value wrong");
    mode_reset_a: assert property (@(posedge clock) $rose(rstn) |->
        cfg_d.baud_sel == uart_cfg_pkg::BAUD_DIV13 && !cfg_d.rx_clk_nodelay
        && !cfg_d.irq_pulse && !cfg_e.fifo_err_new && cfg_e.irq_sel == 4'h4)
        else $error("mode or irq reset value wrong");
    act_write_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_act && dev == `DEV_F |=> cfg_f.active == $past(pwdata[0]))
        else $error("activation write not applied");
    base_align_a: assert property (@(posedge clock) disable iff (!rstn)
        cfg_d.base[2:0] == 3'h0 && cfg_e.base[2:0] == 3'h0 && cfg_f.base[2:0] == 3'h0)
        else $error("base address not 8-byte aligned");
    irq_write_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_irq && dev == `DEV_E |=> cfg_e.irq_sel == $past(pwdata[3:0])
        ##1 $stable(cfg_e.irq_sel) || $past(wr_en))
        else $error("irq select write not applied");
    pulse_mode_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_mode && dev == `DEV_D |=>
        cfg_d.irq_pulse == $past(pwdata[6]) && cfg_d.fifo_err_new == $past(pwdata[5]))
        else $error("mode write not applied");
    baud13_a: assert property (@(posedge clock) disable iff (!rstn)
        baud_tick_d && gap_clean && cfg_d.baud_sel == uart_cfg_pkg::BAUD_DIV13 |-> gap_d == 5'h0D)
        else $error("divide by 13 spacing wrong");
    baud24_a: assert property (@(posedge clock) disable iff (!rstn)
        tick_24mhz && cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV1
        && $stable(cfg_e.baud_sel) |=> baud_tick_e)
        else $error("undivided baud source missed a tick");
    rx_reserved_a: assert property (@(posedge clock) disable iff (!rstn)
        !cfg_e.rx_clk_nodelay)
        else $error("device E reserved delay bit set");

    // Bus answer: one ready per setup, data and error only with it
    ready_after_setup_a: assert property (@(posedge clock) disable iff (!rstn)
        setup
        |=> pready)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
        pready
        |=> !pready)
        else $error("ready held past one cycle");
    err_with_ready_a: assert property (@(posedge clock) disable iff (!rstn)
        pslverr
        |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (@(posedge clock) disable iff (!rstn)
        !pready
        |-> prdata == 32'h00000000)
        else $error("read data outside access");
    rdata_upper_a: assert property (@(posedge clock) disable iff (!rstn)
        pready
        |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    unmapped_write_a: assert property (@(posedge clock) disable iff (!rstn)
        psel && penable && pready && pwrite && !mapped
        |=> $stable(cfg_d) && $stable(cfg_e) && $stable(cfg_f))
        else $error("refused write changed a setting");
    reg_stable_a: assert property (@(posedge clock) disable iff (!rstn)
        !wr_en
        |=> $stable(cfg_d) && $stable(cfg_e) && $stable(cfg_f))
        else $error("setting changed without a write");

    // Register writes land on the next edge
    act_write_d_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_act && dev == `DEV_D
        |=> cfg_d.active == $past(pwdata[0]))
        else $error("device D activation write not applied");
    act_write_e_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_act && dev == `DEV_E
        |=> cfg_e.active == $past(pwdata[0]))
        else $error("device E activation write not applied");
    base_high_d_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_bh && dev == `DEV_D
        |=> cfg_d.base[11:8] == $past(pwdata[3:0]))
        else $error("device D base high write not applied");
    base_high_e_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_bh && dev == `DEV_E
        |=> cfg_e.base[11:8] == $past(pwdata[3:0]))
        else $error("device E base high write not applied");
    base_high_f_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_bh && dev == `DEV_F
        |=> cfg_f.base[11:8] == $past(pwdata[3:0]))
        else $error("device F base high write not applied");
    base_low_d_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_bl && dev == `DEV_D
        |=> cfg_d.base[7:3] == $past(pwdata[7:3]))
        else $error("device D base low write not applied");
    base_low_e_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_bl && dev == `DEV_E
        |=> cfg_e.base[7:3] == $past(pwdata[7:3]))
        else $error("device E base low write not applied");
    base_low_f_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_bl && dev == `DEV_F
        |=> cfg_f.base[7:3] == $past(pwdata[7:3]))
        else $error("device F base low write not applied");
    irq_write_d_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_irq && dev == `DEV_D
        |=> cfg_d.irq_sel == $past(pwdata[3:0]))
        else $error("device D irq select write not applied");
    irq_write_f_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_irq && dev == `DEV_F
        |=> cfg_f.irq_sel == $past(pwdata[3:0]))
        else $error("device F irq select write not applied");
    mode_write_e_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_mode && dev == `DEV_E
        |=> cfg_e.irq_pulse == $past(pwdata[6]) && cfg_e.fifo_err_new == $past(pwdata[5]))
        else $error("device E mode write not applied");
    baud_write_d_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_mode && dev == `DEV_D
        |=> cfg_d.baud_sel == uart_cfg_pkg::baud_sel_e'($past(pwdata[1:0])))
        else $error("device D baud code write not applied");
    baud_write_e_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_mode && dev == `DEV_E
        |=> cfg_e.baud_sel == uart_cfg_pkg::baud_sel_e'($past(pwdata[1:0])))
        else $error("device E baud code write not applied");
    rx_delay_write_a: assert property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_mode && dev == `DEV_D
        |=> cfg_d.rx_clk_nodelay == $past(pwdata[7]))
        else $error("receive delay write not applied");

    // Reserved bits read as zero
    act_upper_a: assert property (@(posedge clock) disable iff (!rstn)
        act_q[0][7:1] == 7'h00 && act_q[1][7:1] == 7'h00
        && act_q[2][7:1] == 7'h00)
        else $error("activation reserved bits set");
    irq_upper_a: assert property (@(posedge clock) disable iff (!rstn)
        irq_q[0][7:4] == 4'h0 && irq_q[1][7:4] == 4'h0
        && irq_q[2][7:4] == 4'h0)
        else $error("irq select reserved bits set");
    mode_reserved_a: assert property (@(posedge clock) disable iff (!rstn)
        mode_q[0][4:2] == 3'h0 && mode_q[1][4:2] == 3'h0
        && !mode_q[1][7])
        else $error("mode reserved bits set");

    // Reset values seen at the first edge after release
    irq_reset_a: assert property (@(posedge clock) $rose(rstn)
        |-> cfg_d.irq_sel == 4'h3
        && cfg_f.irq_sel == 4'h3)
        else $error("irq select reset value wrong");
    mode_reset_e_a: assert property (@(posedge clock) $rose(rstn)
        |-> cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV13
        && !cfg_e.irq_pulse && !cfg_d.fifo_err_new)
        else $error("device E mode reset value wrong");

    // Baud sources: ticks only after a 24 MHz tick, spaced by the code
    tick_idle_a: assert property (@(posedge clock) disable iff (!rstn)
        !tick_24mhz
        |=> !baud_tick_d && !baud_tick_e)
        else $error("baud tick without a 24 MHz tick");
    baud_gap_d_a: assert property (@(posedge clock) disable iff (!rstn)
        baud_tick_d && cfg_d.baud_sel == uart_cfg_pkg::BAUD_DIV13 && $stable(cfg_d.baud_sel)
        |=> !baud_tick_d)
        else $error("device D baud ticks back to back");
    baud_gap_e_a: assert property (@(posedge clock) disable iff (!rstn)
        baud_tick_e && cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV12 && $stable(cfg_e.baud_sel)
        |=> !baud_tick_e)
        else $error("device E baud ticks back to back");
    baud12_a: assert property (@(posedge clock) disable iff (!rstn)
        baud_tick_e && gap_e_clean && cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV12
        |-> gap_e == 5'h0C)
        else $error("divide by 12 spacing wrong");

    act_write_c: cover property (@(posedge clock) disable iff (!rstn)
        wr_en && hit_act && pwdata[0]);
    pulse_mode_c: cover property (@(posedge clock) disable iff (!rstn) cfg_d.irq_pulse);
    baud_frac_c: cover property (@(posedge clock) disable iff (!rstn)
        cfg_e.baud_sel == uart_cfg_pkg::BAUD_DIV1625 && baud_tick_e);
    unmapped_c: cover property (@(posedge clock) disable iff (!rstn) pslverr);
    baud12_c: cover property (@(posedge clock) disable iff (!rstn) baud_tick_e && gap_e_clean);
endmodule : uart_cfg_bank

/* testbench/apb_host.sv */
// APB master model standing in for host software.
// Assumes a zero-or-more wait-state slave on one rising-edge clock.
module apb_host (
    input wire logic clock, // System clock
    input wire logic pready, // Slave ready
    input wire logic [31:0] prdata, // Slave read data
    input wire logic pslverr, // Slave error
    output logic psel, // Select
    output logic penable, // Enable
    output logic pwrite, // Direction
    output logic [31:0] paddr, // Byte address
    output logic [31:0] pwdata // Write data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

/* testbench/uart_logical_device_config_tb_top.sv */
// Self-checking bench for the serial-port configuration bank.
// Assumes the bank answers APB and divides a 24 MHz enable as noted.
module uart_logical_device_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, rstn, psel, penable, pwrite, pready, pslverr, tick_24mhz;
    logic [31:0] paddr, pwdata, prdata, q;
    logic err, baud_tick_d, baud_tick_e, tick_on, cnt_on;
    logic [7:0] vals [3][5];
    uart_cfg_pkg::dev_cfg_s cfg_d, cfg_e, cfg_f, cur;
    int fails, checks, cyc, nd, ne;
    integer seed = 32'hED8A9E7A;
    logic [31:0] w;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    apb_host i_host (.clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    uart_cfg_bank i_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tick_24mhz(tick_24mhz), .cfg_d(cfg_d),
        .cfg_e(cfg_e), .cfg_f(cfg_f), .baud_tick_d(baud_tick_d),
        .baud_tick_e(baud_tick_e));

    function automatic logic [31:0] addr(int d, int i);
        logic [31:0] idx;
        idx = (i == 0) ? 32'h30 : (i == 1) ? 32'h60 : (i == 2) ? 32'h61 :
              (i == 3) ? 32'h70 : 32'hF0;
        return d * 32'h400 + idx * 32'h4;
    endfunction : addr

    function automatic logic [7:0] rst_v(int d, int i);
        case (i)
            1: return (d == 1) ? 8'h03 : 8'h02;
            2: return (d == 0) ? 8'hE0 : 8'hE8;
            3: return (d == 1) ? 8'h04 : 8'h03;
            default: return 8'h00;
        endcase
    endfunction : rst_v

    function automatic logic [7:0] mask_v(int d, int i);
        case (i)
            0: return 8'h01;
            1: return 8'h0F;
            2: return 8'hF8;
            3: return 8'h0F;
            default: return (d == 0) ? 8'hE3 : 8'h63;
        endcase
    endfunction : mask_v

    function automatic uart_cfg_pkg::dev_cfg_s exp_cfg(int d);
        uart_cfg_pkg::dev_cfg_s c;
        logic [7:0] m;
        m = (d == 2) ? 8'h00 : vals[d][4];
        c.active = vals[d][0][0];
        c.base = {vals[d][1][3:0], vals[d][2]};
        c.irq_sel = vals[d][3][3:0];
        c.irq_pulse = m[6];
        c.fifo_err_new = m[5];
        c.rx_clk_nodelay = m[7];
        c.baud_sel = uart_cfg_pkg::baud_sel_e'(m[1:0]);
        return c;
    endfunction : exp_cfg

    function automatic int baud_n(int code);
        return (code == 0) ? 12 : (code == 1) ? 13 : (code == 2) ? 156 : 96;
    endfunction : baud_n

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // Random 24 MHz enables, solid during baud counting
    always @(posedge clock) begin
        tick_24mhz <= tick_on | (($random(seed) & 1) != 0);
        cyc <= cyc + 1;
        if (cnt_on) begin
            nd <= nd + int'(baud_tick_d);
            ne <= ne + int'(baud_tick_e);
        end
        if (cyc == 6000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        rstn = 1'b0;
        tick_24mhz = 1'b0;
        tick_on = 1'b0;
        cnt_on = 1'b0;
        cyc = 0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        for (int d = 0; d < 3; d++) begin
            for (int i = 0; i < 5; i++) begin
                if (d == 2 && i == 4) continue;
                i_host.xfer(1'b0, addr(d, i), 32'h0, q, err);
                chk(q, {24'h0, rst_v(d, i)});
            end
        end
        chk({31'h0, cfg_d.rx_clk_nodelay}, 32'h0);
        // All ones, all zeros, then random values
        for (int r = 0; r < 4; r++) begin
            for (int d = 0; d < 3; d++) begin
                for (int i = 0; i < 5; i++) begin
                    if (d == 2 && i == 4) continue;
                    w = (r == 0) ? 32'hFFFFFFFF : (r == 1) ? 32'h0 : $random(seed);
                    vals[d][i] = w[7:0] & mask_v(d, i);
                    i_host.xfer(1'b1, addr(d, i), w, q, err);
                    i_host.xfer(1'b0, addr(d, i), 32'h0, q, err);
                    chk(q, {24'h0, vals[d][i]});
                end
                vals[2][4] = 8'h00;
                cur = (d == 0) ? cfg_d : (d == 1) ? cfg_e : cfg_f;
                chk({10'h0, cur}, {10'h0, exp_cfg(d)});
            end
        end
        // Unmapped places are refused
        i_host.xfer(1'b1, addr(2, 4), 32'hFF, q, err);
        chk({31'h0, err}, 32'h1);
        i_host.xfer(1'b0, 32'hC00, 32'h0, q, err);
        chk({err, q[30:0]}, 32'h80000000);
        for (int code = 0; code < 4; code++) begin
            i_host.xfer(1'b1, addr(0, 4), code, q, err);
            i_host.xfer(1'b1, addr(1, 4), code, q, err);
            tick_on <= 1'b1;
            repeat (160) @(posedge clock);
            nd = 0;
            ne = 0;
            cnt_on <= 1'b1;
            repeat (156) @(posedge clock);
            cnt_on <= 1'b0;
            tick_on <= 1'b0;
            @(posedge clock);
            chk(nd, baud_n(code));
            chk(ne, baud_n(code));
        end
        test_done();
    end
endmodule : uart_logical_device_config_tb_top
